/* swc_aux_model.sv */
`timescale 1ns/1ns
module swc_aux_model (
  // clock
  input  wire       pclk,
  // relay coils
  input  wire       close_cmd_out,
  input  wire       open_cmd_out,
  // travel clocks, 15 never arrives
  input  wire [3:0] dly,
  // auxiliary contacts
  output logic      aux_close_in,
  output logic      aux_open_in
);
  int n = 0;
  initial begin
    aux_close_in = 1'b0;
    aux_open_in  = 1'b1;
  end
  // both contacts leave their end position once the mechanism moves
  always @(posedge pclk) begin
    n <= (close_cmd_out || open_cmd_out) ? n + 1 : 0;
    if (n == 1) begin
      aux_close_in <= 1'b0;
      aux_open_in  <= 1'b0;
    end
    if (n == dly && close_cmd_out) aux_close_in <= 1'b1;
    if (n == dly && open_cmd_out) aux_open_in <= 1'b1;
  end
endmodule

/* swc_defines.vh */
// Overview of operation
// - open command starts open travel, shows intermediate
// - timely feedback gives target, expiry gives faulted
// - two contacts decode open, closed, intermediate, faulted
// - one contact wired raises single contact flag
// - single contact supervises its own direction only
// - close-only: timely close gives closed and success
// - close-only expiry: faulted, settle, then closed
// - close contact unassigned alone: close unsupervised, assumed closed
// - open-only: timely open gives open and success
// - open-only expiry: faulted, settle, then open
// - open contact unassigned alone: open unsupervised, assumed open
// - three interlocks per direction block switching
// - protection open and auto_reclose bypass interlocks
// - close command starts close travel, intermediate
// - command output lasts at most travel time
// - code 0 interm, 1 open, 2 closed, 3 faulted
`ifndef SWC_DEFINES_VH
`define SWC_DEFINES_VH
// ==========================================
// register offsets
`define SWC_OFS_CTRL      12'h000
`define SWC_OFS_CMD       12'h004
`define SWC_OFS_T_CLOSE   12'h008
`define SWC_OFS_T_OPEN    12'h00C
`define SWC_OFS_T_SETTLE  12'h010
`define SWC_OFS_STATUS    12'h014
// ==========================================
// control fields
`define SWC_CTRL_CLOSE_WIRED 0
`define SWC_CTRL_OPEN_WIRED  1
`define SWC_CTRL_IL_CLOSE_LO 2
`define SWC_CTRL_IL_OPEN_LO  5
`define SWC_CMD_CLOSE        0
`define SWC_CMD_OPEN         1
// ==========================================
// reset values (durations in clock cycles)
`define SWC_CTRL_RST     8'h03
`define SWC_T_CLOSE_RST  32'h0000_1000
`define SWC_T_OPEN_RST   32'h0000_1000
`define SWC_T_SETTLE_RST 32'h0000_0000
// ==========================================
// state codes
`define SWC_CODE_INTERM 2'h0
`define SWC_CODE_OPEN   2'h1
`define SWC_CODE_CLOSED 2'h2
`define SWC_CODE_FAULT  2'h3
`endif

/* swc_position_supervisor.v */
`timescale 1ns/1ns
`include "swc_defines.vh"

module swc_position_supervisor #(
  parameter IL_N = 3
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // auxiliary contacts
  input  wire        aux_close_in,
  input  wire        aux_open_in,
  // interlocks, active high blocks
  input  wire [IL_N-1:0] il_close_in,
  input  wire [IL_N-1:0] il_open_in,
  // bypass command sources and their block input
  input  wire        prot_open_in,
  input  wire        auto_reclose_in,
  input  wire        bypass_block_in,
  // relay outputs
  output reg         close_cmd_out,
  output reg         open_cmd_out,
  // validated position
  output reg  [1:0]  state_code,
  output reg         pos_closed,
  output reg         pos_open,
  output reg         pos_interm,
  output reg         pos_fault,
  output reg         single_contact_flag,
  output reg         switch_success_flag
);

  // ==========================================
  // fsm states
  localparam [3:0] S_IDLE   = 4'b0001;
  localparam [3:0] S_CLOSE  = 4'b0010;
  localparam [3:0] S_OPEN   = 4'b0100;
  localparam [3:0] S_SETTLE = 4'b1000;

  // ==========================================
  // registers
  reg  [7:0]  ctrl_q;
  reg  [31:0] t_close_q;
  reg  [31:0] t_open_q;
  reg  [31:0] t_settle_q;
  reg  [1:0]  sync1_q;
  reg  [1:0]  sync2_q;
  reg         prot_q;
  reg         arc_q;
  reg  [3:0]  st_q;
  reg  [3:0]  st_d;
  reg  [31:0] cnt_q;
  reg  [31:0] cnt_d;
  reg         sup_q;
  reg         sup_d;
  reg         fault_q;
  reg         fault_d;
  reg         assume_q;
  reg         assume_d;
  reg         succ_d;
  reg         refused_q;
  reg         refused_d;
  reg         close_d;
  reg         open_d;
  reg  [1:0]  code_d;

  wire        wr_en;
  wire        rd_en;
  wire        cw;
  wire        ow;
  wire        ac;
  wire        ao;
  wire        sw_close;
  wire        sw_open;
  wire        prot_rise;
  wire        arc_rise;
  wire        il_close_blk;
  wire        il_open_blk;
  wire        req_open;
  wire        req_close;
  wire        byp_open;
  wire        byp_close;
  wire        single;
  reg         addr_ok;
  reg  [31:0] rd_mux;

  // ==========================================
  // apb access, one wait-free access cycle
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `SWC_OFS_CTRL:     rd_mux = {24'h00_0000, ctrl_q};
      `SWC_OFS_CMD:      rd_mux = 32'h0000_0000;
      `SWC_OFS_T_CLOSE:  rd_mux = t_close_q;
      `SWC_OFS_T_OPEN:   rd_mux = t_open_q;
      `SWC_OFS_T_SETTLE: rd_mux = t_settle_q;
      `SWC_OFS_STATUS:   rd_mux = {21'h00_0000, refused_q, open_cmd_out,
                                   close_cmd_out, switch_success_flag,
                                   single_contact_flag, pos_fault, pos_interm,
                                   pos_open, pos_closed, state_code};
      default:           addr_ok = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      ctrl_q     <= `SWC_CTRL_RST;
      t_close_q  <= `SWC_T_CLOSE_RST;
      t_open_q   <= `SWC_T_OPEN_RST;
      t_settle_q <= `SWC_T_SETTLE_RST;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~addr_ok;
      if (rd_en)
        prdata <= addr_ok ? rd_mux : 32'h0000_0000;
      if (wr_en && paddr == `SWC_OFS_CTRL)
        ctrl_q <= pwdata[7:0];
      if (wr_en && paddr == `SWC_OFS_T_CLOSE)
        t_close_q <= pwdata;
      if (wr_en && paddr == `SWC_OFS_T_OPEN)
        t_open_q <= pwdata;
      if (wr_en && paddr == `SWC_OFS_T_SETTLE)
        t_settle_q <= pwdata;
    end
  end

  // command register is write-only, each write is a one-cycle request
  assign sw_close = wr_en & (paddr == `SWC_OFS_CMD) & pwdata[`SWC_CMD_CLOSE];
  assign sw_open  = wr_en & (paddr == `SWC_OFS_CMD) & pwdata[`SWC_CMD_OPEN];

  // ==========================================
  // input conditioning
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 2'b00;
      sync2_q <= 2'b00;
      prot_q  <= 1'b0;
      arc_q   <= 1'b0;
    end else begin
      sync1_q <= {aux_open_in, aux_close_in};
      sync2_q <= sync1_q;
      prot_q  <= prot_open_in;
      arc_q   <= auto_reclose_in;
    end
  end

  assign ac = sync2_q[0];
  assign ao = sync2_q[1];
  assign cw = ctrl_q[`SWC_CTRL_CLOSE_WIRED];
  assign ow = ctrl_q[`SWC_CTRL_OPEN_WIRED];
  assign single = cw ^ ow;

  // bypass sources act on their rising edge; a held trip fires once
  assign prot_rise = prot_open_in & ~prot_q;
  assign arc_rise  = auto_reclose_in & ~arc_q;

  // only enabled interlock inputs count
  assign il_close_blk = |(il_close_in & ctrl_q[`SWC_CTRL_IL_CLOSE_LO +: IL_N]);
  assign il_open_blk  = |(il_open_in & ctrl_q[`SWC_CTRL_IL_OPEN_LO +: IL_N]);

  assign byp_open  = prot_rise & ~bypass_block_in;
  assign byp_close = arc_rise & ~bypass_block_in;
  assign req_open  = byp_open | (sw_open & ~il_open_blk);
  assign req_close = byp_close | (sw_close & ~il_close_blk);

  // ==========================================
  // command sequencer
  always @* begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    sup_d     = sup_q;
    fault_d   = fault_q;
    assume_d  = assume_q;
    succ_d    = switch_success_flag;
    refused_d = refused_q;
    close_d   = 1'b0;
    open_d    = 1'b0;
    case (st_q)
      S_IDLE, S_SETTLE: begin
        if (st_q == S_SETTLE) begin
          if (fault_q) begin
            // first settle cycle only shows the fault, the count waits
            fault_d = 1'b0;
          end else if (cnt_q <= 32'h0000_0001) begin
            st_d     = S_IDLE;
            fault_d  = 1'b0;
            assume_d = 1'b1;
          end else begin
            cnt_d = cnt_q - 32'h0000_0001;
          end
        end
        // open wins when both arrive together
        if (req_open) begin
          st_d      = S_OPEN;
          cnt_d     = (t_open_q == 32'h0000_0000) ? 32'h0000_0001 : t_open_q;
          sup_d     = ow;
          fault_d   = 1'b0;
          assume_d  = 1'b0;
          succ_d    = 1'b0;
          // a software close lost to a bypass open is still refused
          refused_d = sw_close & ~sw_open;
          open_d    = 1'b1;
        end else if (req_close) begin
          st_d      = S_CLOSE;
          cnt_d     = (t_close_q == 32'h0000_0000) ? 32'h0000_0001 : t_close_q;
          sup_d     = cw;
          fault_d   = 1'b0;
          assume_d  = 1'b0;
          succ_d    = 1'b0;
          // an interlocked software open stays refused when a close goes ahead
          refused_d = sw_open;
          close_d   = 1'b1;
        end else if (sw_open | sw_close) begin
          refused_d = 1'b1;
        end
      end
      S_OPEN, S_CLOSE: begin
        // software commands while moving are dropped and flagged; bypass edges are dropped unflagged
        if (sw_open | sw_close)
          refused_d = 1'b1;
        if (((st_q == S_OPEN) && ao && (!cw || !ac)) ||
            ((st_q == S_CLOSE) && ac && (!ow || !ao))) begin
          // target reached: output ends early
          st_d   = S_IDLE;
          succ_d = sup_q;
        end else if (cnt_q == 32'h0000_0001) begin
          // travel time spent: output drops, supervision decides
          st_d    = S_IDLE;
          fault_d = sup_q;
          if (sup_q && single && t_settle_q != 32'h0000_0000) begin
            st_d  = S_SETTLE;
            cnt_d = t_settle_q;
          end else if (!sup_q) begin
            assume_d = 1'b1;
          end
        end else begin
          cnt_d   = cnt_q - 32'h0000_0001;
          close_d = (st_q == S_CLOSE);
          open_d  = (st_q == S_OPEN);
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  // ==========================================
  // position decode
  // the fault shown after expiry lasts at least one cycle even when a
  // settle phase follows, so software can see the failed transfer
  always @* begin
    code_d = `SWC_CODE_FAULT;
    if (cw && ow) begin
      if (ao && !ac)
        code_d = `SWC_CODE_OPEN;
      else if (ac && !ao)
        code_d = `SWC_CODE_CLOSED;
      else if (st_q == S_OPEN || st_q == S_CLOSE)
        code_d = `SWC_CODE_INTERM;
      else
        code_d = `SWC_CODE_FAULT;
    end else if (cw) begin
      if (ac)
        code_d = `SWC_CODE_CLOSED;
      else if (sup_q && st_q == S_CLOSE)
        code_d = `SWC_CODE_INTERM;
      else if (fault_q)
        code_d = `SWC_CODE_FAULT;
      else if (st_q == S_SETTLE)
        code_d = `SWC_CODE_INTERM;
      else if (assume_q && sup_q)
        code_d = `SWC_CODE_CLOSED;
      else
        code_d = `SWC_CODE_OPEN;
    end else if (ow) begin
      if (ao)
        code_d = `SWC_CODE_OPEN;
      else if (sup_q && st_q == S_OPEN)
        code_d = `SWC_CODE_INTERM;
      else if (fault_q)
        code_d = `SWC_CODE_FAULT;
      else if (st_q == S_SETTLE)
        code_d = `SWC_CODE_INTERM;
      else if (assume_q && sup_q)
        code_d = `SWC_CODE_OPEN;
      else
        code_d = `SWC_CODE_CLOSED;
    end else begin
      code_d = `SWC_CODE_FAULT;
    end
  end

  // ==========================================
  // state and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q                <= S_IDLE;
      cnt_q               <= 32'h0000_0000;
      sup_q               <= 1'b0;
      fault_q             <= 1'b0;
      assume_q            <= 1'b0;
      refused_q           <= 1'b0;
      switch_success_flag <= 1'b0;
      close_cmd_out       <= 1'b0;
      open_cmd_out        <= 1'b0;
      state_code          <= `SWC_CODE_FAULT;
      pos_closed          <= 1'b0;
      pos_open            <= 1'b0;
      pos_interm          <= 1'b0;
      pos_fault           <= 1'b1;
      single_contact_flag <= 1'b0;
    end else begin
      st_q                <= st_d;
      cnt_q               <= cnt_d;
      sup_q               <= sup_d;
      fault_q             <= fault_d;
      assume_q            <= assume_d;
      refused_q           <= refused_d;
      switch_success_flag <= succ_d;
      close_cmd_out       <= close_d;
      open_cmd_out        <= open_d;
      state_code          <= code_d;
      pos_closed          <= (code_d == `SWC_CODE_CLOSED);
      pos_open            <= (code_d == `SWC_CODE_OPEN);
      pos_interm          <= (code_d == `SWC_CODE_INTERM);
      pos_fault           <= (code_d == `SWC_CODE_FAULT);
      single_contact_flag <= single;
    end
  end

endmodule

/* swc_position_supervisor_asserts.sv */
`timescale 1ns/1ns
`include "swc_defines.vh"
module swc_position_supervisor_asserts (
  // clock and reset
  input wire       pclk,
  input wire       presetn,
  // apb handshake
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  // contacts and relays
  input wire       aux_close_in,
  input wire       aux_open_in,
  input wire       close_cmd_out,
  input wire       open_cmd_out,
  // position
  input wire [1:0] state_code,
  input wire       pos_closed,
  input wire       pos_open,
  input wire       pos_interm,
  input wire       pos_fault,
  input wire       single_contact_flag,
  input wire       switch_success_flag
);
  // ======
  // bench programs both travel times to this
  localparam int TRAVEL = 8;
  wire dual_idle = !single_contact_flag && !close_cmd_out && !open_cmd_out;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // four samples cover two sync stages plus the output register
  sequence s_closed; (dual_idle && aux_close_in && !aux_open_in) [*4]; endsequence
  sequence s_open; (dual_idle && !aux_close_in && aux_open_in) [*4]; endsequence
  property p_closed; s_closed |=> state_code == `SWC_CODE_CLOSED; endproperty
  property p_open; s_open |=> state_code == `SWC_CODE_OPEN; endproperty
  // a clean end position still decodes as such; equal contacts reach the code three samples late
  property p_close_mv;
    !single_contact_flag && close_cmd_out && $past(close_cmd_out) &&
    ($past(aux_close_in, 3) == $past(aux_open_in, 3)) |-> state_code == `SWC_CODE_INTERM;
  endproperty
  property p_open_mv;
    !single_contact_flag && open_cmd_out && $past(open_cmd_out) &&
    ($past(aux_close_in, 3) == $past(aux_open_in, 3)) |-> state_code == `SWC_CODE_INTERM;
  endproperty
  property p_close_len; $rose(close_cmd_out) |-> ##[1:TRAVEL] !close_cmd_out; endproperty
  property p_open_len; $rose(open_cmd_out) |-> ##[1:TRAVEL] !open_cmd_out; endproperty
  property p_onehot; {pos_fault, pos_closed, pos_open, pos_interm} == 4'h1 << state_code; endproperty
  property p_success; $rose(switch_success_flag) |-> state_code inside {2'h1, 2'h2}; endproperty
  property p_ready; psel && !penable |=> pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  a_closed: assert property (p_closed) else $error("closed not decoded");
  a_open: assert property (p_open) else $error("open not decoded");
  a_close_mv: assert property (p_close_mv) else $error("close travel not intermediate");
  a_open_mv: assert property (p_open_mv) else $error("open travel not intermediate");
  a_close_len: assert property (p_close_len) else $error("close relay too long");
  a_open_len: assert property (p_open_len) else $error("open relay too long");
  a_onehot: assert property (p_onehot) else $error("position flags disagree");
  a_success: assert property (p_success) else $error("success without end position");
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_err: assert property (p_err) else $error("error without ready");
endmodule
bind swc_position_supervisor swc_position_supervisor_asserts u_chk (.*);

/* swc_position_supervisor_tb_top.sv */
`timescale 1ns/1ns
`include "swc_defines.vh"
module swc_position_supervisor_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sg = 0, sf;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, ts;
  logic        pready, pslverr, close_cmd_out, open_cmd_out, aux_close_in, aux_open_in;
  logic [2:0]  il_close_in = 0, il_open_in = 0;
  logic        prot_open_in = 0, auto_reclose_in = 0, bypass_block_in = 0;
  logic [1:0]  state_code;
  logic        pos_closed, pos_open, pos_interm, pos_fault, single_contact_flag, switch_success_flag;
  logic [3:0]  dly = 3;
  logic [64:0] q[$], en;
  int          mismatches = 0, num_checks = 0, k, n;
  swc_position_supervisor dut (.*);
  swc_aux_model model (.*);
  always #5 pclk = ~pclk;
  // ======
  function automatic logic [32:0] st(input logic [1:0] c, input logic u, input logic r);
    st = {22'h0, r, 2'b00, u, sg, c == 2'h3, c == 2'h0, c == 2'h1, c == 2'h2, c};
  endfunction
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
    if (t == 20) mismatches++;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
    q.push_back({e, m});
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic rs(input logic [1:0] c, input logic u, input logic r, input logic [31:0] m);
    rd(`SWC_OFS_STATUS, st(c, u, r), m);
  endtask
  // a refused command never raises a relay, so the first wait simply runs out
  task automatic wrel();
    int t;
    t = 0;
    do @(posedge pclk); while (!(close_cmd_out || open_cmd_out) && ++t < 20);
    do @(posedge pclk); while ((close_cmd_out || open_cmd_out) && ++t < 40);
  endtask
  task automatic cmd(input int b, input logic [3:0] d, input logic [1:0] c, input logic u);
    dly <= d;
    apb(`SWC_OFS_CMD, 1'b1, 32'h1 << b);
    wrel();
    repeat (4) @(posedge pclk);
    rs(c, u, 0, 32'h7FF);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ======
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      en = q.pop_front();
      chk({pslverr, prdata & en[31:0]}, {en[64], en[63:32] & en[31:0]});
    end
  end
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    ts = $urandom(32'h634FEF7C);
    ts = 1 + $urandom % 8;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`SWC_OFS_CTRL, {25'h0, `SWC_CTRL_RST}, '1);
    rd(`SWC_OFS_T_OPEN, {1'b0, `SWC_T_OPEN_RST}, '1);
    rd(`SWC_OFS_CMD, 33'h0, '1);
    rd(12'h018, {1'b1, 32'h0}, '1);
    apb(`SWC_OFS_T_CLOSE, 1'b1, 32'h8);
    apb(`SWC_OFS_T_OPEN, 1'b1, 32'h8);
    apb(`SWC_OFS_T_SETTLE, 1'b1, ts);
    rd(`SWC_OFS_T_SETTLE, {1'b0, ts}, '1);
    rs(`SWC_CODE_OPEN, 0, 0, 32'hFF);
    cmd(0, 3, `SWC_CODE_CLOSED, 1);
    cmd(1, 15, `SWC_CODE_FAULT, 0);
    cmd(0, 3, `SWC_CODE_CLOSED, 1);
    for (k = 0; k < 3; k++) begin
      il_close_in <= 3'h1 << k;
      il_open_in <= 3'h1 << k;
      apb(`SWC_OFS_CTRL, 1'b1, 32'h3 | (32'h24 << k));
      apb(`SWC_OFS_CMD, 1'b1, 32'h2);
      rs(`SWC_CODE_CLOSED, 1, 1, 32'h7FF);
      prot_open_in <= 1;
      wrel();
      prot_open_in <= 0;
      repeat (4) @(posedge pclk);
      rs(`SWC_CODE_OPEN, 1, 0, 32'h7FF);
      bypass_block_in <= 1;
      auto_reclose_in <= 1;
      wrel();
      rs(`SWC_CODE_OPEN, 1, 0, 32'h3FF);
      bypass_block_in <= 0;
      auto_reclose_in <= 0;
      @(posedge pclk);
      auto_reclose_in <= 1;
      wrel();
      auto_reclose_in <= 0;
      repeat (4) @(posedge pclk);
      rs(`SWC_CODE_CLOSED, 1, 0, 32'h3FF);
    end
    il_close_in <= 0;
    il_open_in <= 0;
    sg = 1;
    // the breaker sits closed here, so open-only goes first and no target is met at once
    for (k = 1; k >= 0; k--) begin
      apb(`SWC_OFS_CTRL, 1'b1, 32'h1 << k);
      dly <= 15;
      apb(`SWC_OFS_CMD, 1'b1, 32'h1 << k);
      wrel();
      sf = pos_fault;
      n = 0;
      repeat (30) begin
        @(posedge pclk);
        sf |= pos_fault;
        n += sf && pos_interm;
      end
      chk(sf, 1);
      chk(n, ts);
      chk(state_code, k ? `SWC_CODE_OPEN : `SWC_CODE_CLOSED);
      cmd(k, 3, k ? `SWC_CODE_OPEN : `SWC_CODE_CLOSED, 1);
    end
    cmd(1, 15, `SWC_CODE_OPEN, 0);
    sg = 0;
    apb(`SWC_OFS_CTRL, 1'b1, 32'h0);
    rs(`SWC_CODE_FAULT, 0, 0, 32'hFF);
    report_and_stop();
  end
endmodule
